// ===== hdl/sbl_pkg.sv
// Constants, types and helpers shared by the SPI boot loader port
package sbl_pkg;

    // Kernel geometry: 256 instructions of 48 bits moved as 32-bit words
    localparam int          DATA_W        = 32;
    localparam int          KERNEL_INSTR  = 256;
    localparam logic [8:0]  KERNEL_WORDS  = 9'h180;

    // Master boot read command, opcode then address
    localparam logic [7:0]  READ_OPCODE   = 8'h03;
    localparam logic [23:0] READ_ADDR     = 24'h000000;

    // Register offsets on the plain register port
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_STATUS    = 4'h4;
    localparam logic [3:0]  REG_RXBUF     = 4'h8;
    localparam logic [3:0]  REG_COUNT     = 4'hc;

    // Status field positions
    localparam int          STAT_DONE     = 0;
    localparam int          STAT_MASTER   = 1;
    localparam int          STAT_SELECT   = 2;
    localparam int          STAT_BREAK    = 3;
    localparam int          STAT_STATE_LO = 4;

    // Word length code for 32-bit words, the only one used in boot
    localparam logic [1:0]  WL_32BIT      = 2'h2;

    typedef struct packed {
        logic       clock_phase_bit;
        logic       clock_polarity_bit;
        logic       receive_dma_enable_bit;
        logic       send_zero_select_bit;
        logic       serial_out_disable_bit;
        logic [1:0] word_length_field;
        logic       msb_first_bit;
        logic       master_select_bit;
        logic       port_enable_bit;
    } sbl_ctrl_t;

    // Slave boot defaults
    localparam sbl_ctrl_t CTRL_RESET = 10'h3b1;

    typedef struct packed {
        logic        we;
        logic [8:0]  addr;
        logic [31:0] data;
    } sbl_mem_wr_t;

    typedef enum logic [2:0] {
        ST_STRAP,
        ST_SARM,
        ST_SDATA,
        ST_CMD,
        ST_MDATA,
        ST_DONE
    } sbl_state_t;

    function automatic logic [7:0] sbl_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction : sbl_rev8

    // One bit into a 32-bit word, LSB first unless msb is set
    function automatic logic [31:0] sbl_shift_in(input logic [31:0] w,
                                                 input logic        b,
                                                 input logic        msb);
        logic [31:0] r;
        r = msb ? {w[30:0], b} : {b, w[31:1]};
        return r;
    endfunction : sbl_shift_in

endpackage : sbl_pkg

// ===== hdl/sbl_port.sv
// SPI boot loader port: slave and master boot of the 256-instruction kernel
//
// Notes on behaviour
// - After reset one DMA loads the 256-instruction kernel before anything else.
// - Sources of 8, 16 or 32 bits; shift register stays 32 bits.
// - Incoming bits packed LSB first into 32-bit words, each then stored.
// - Slave boot DMA count is 384 words, filled one word at a time.
// - Slave defaults: enabled, slave, LSB first, code 10, output off, DMA on.
// - Slave boot uses active-low clock with phase set.
// - Master boot starts the clock and drives the flag select low.
// - Master boot sends read command 0x03 and address zero.
// - Command is one 32-bit word, opcode then address, shifted LSB first.
// - Opcode sent LSB first reads 0x03 MSB first; address all zeros.
// - Bits received during the command word are dropped by hardware.
// - First stream bit taken on cycle 32; clocking runs until load ends.
// - Default order is LSB first; MSB-first PROM content stored reversed.
`timescale 1ns/10ps
module sbl_port
    import sbl_pkg::*;
#(
    parameter int         SCK_HALF  = 4,
    parameter logic [8:0] DMA_WORDS = sbl_pkg::KERNEL_WORDS
) (
    // System clock and reset
    input  wire  logic                 SYS_CLK,
    input  wire  logic                 RSTN,
    // Boot strap: high selects master boot
    input  wire  logic                 BOOT_MASTER_IN,
    // Slave boot link, clocked by the external host
    input  wire  logic                 LINK_SCK,
    input  wire  logic                 DEVICE_SELECT_N_IN,
    input  wire  logic                 SLAVE_DATA_IN,
    // Master boot link, clocked by this device
    input  wire  logic                 MASTER_DATA_IN,
    output logic                       SCK_OUT,
    output logic                       SCK_OE,
    output logic                       SER_OUT,
    output logic                       SER_OUT_OE,
    output logic                       FLAG_SELECT_N_OUT,
    // Register port
    input  wire  logic [3:0]           REG_ADDR,
    input  wire  logic [31:0]          REG_WDATA,
    input  wire  logic                 REG_WR,
    input  wire  logic                 REG_RD,
    output logic       [31:0]          REG_RDATA,
    // Kernel memory write port and completion
    output sbl_pkg::sbl_mem_wr_t       MEM_WR,
    output logic                       KERNEL_DONE
);
    import sbl_pkg::*;

    localparam logic [7:0] PERIOD_LAST = 8'(2 * SCK_HALF - 1);
    localparam logic [7:0] HALF_CNT    = 8'(SCK_HALF);

    // ---------------- Link clock domain (slave boot) ----------------

    logic [4:0]  lnk_bits_r;
    logic [31:0] lnk_shift_r;
    logic [31:0] lnk_word_r;
    logic        lnk_tog_r;
    logic        lnk_msb_s1_r;
    logic        lnk_msb_s2_r;
    logic [31:0] lnk_shift_nxt;
    logic        lnk_clr;

    sbl_ctrl_t   ctrl_r;

    // A raised select restarts word framing, so a break never leaves a
    // half-built word behind
    assign lnk_clr = DEVICE_SELECT_N_IN | ~RSTN;

    assign lnk_shift_nxt = sbl_shift_in(lnk_shift_r, SLAVE_DATA_IN,
                                        lnk_msb_s2_r);

    always_ff @(posedge LINK_SCK or negedge RSTN) begin
        if (!RSTN) begin
            lnk_msb_s1_r <= 1'b0;
            lnk_msb_s2_r <= 1'b0;
        end else begin
            lnk_msb_s1_r <= ctrl_r.msb_first_bit;
            lnk_msb_s2_r <= lnk_msb_s1_r;
        end
    end

    // Active-low clock with phase set: data sampled on the rising edge
    always_ff @(posedge LINK_SCK or posedge lnk_clr) begin
        if (lnk_clr) begin
            lnk_bits_r <= 5'h00;
        end else begin
            lnk_bits_r <= lnk_bits_r + 5'h01;
        end
    end

    always_ff @(posedge LINK_SCK or negedge RSTN) begin
        if (!RSTN) begin
            lnk_shift_r <= 32'h00000000;
        end else begin
            lnk_shift_r <= lnk_shift_nxt;
        end
    end

    // Word held stable for 32 link clocks, far longer than the crossing
    always_ff @(posedge LINK_SCK or negedge RSTN) begin
        if (!RSTN) begin
            lnk_word_r <= 32'h00000000;
            lnk_tog_r  <= 1'b0;
        end else if (lnk_bits_r == 5'h1f) begin
            lnk_word_r <= lnk_shift_nxt;
            lnk_tog_r  <= ~lnk_tog_r;
        end
    end

    // ---------------- System clock domain ----------------

    logic        tog_s1_r;
    logic        tog_s2_r;
    logic        tog_s3_r;
    logic        sel_s1_r;
    logic        sel_s2_r;
    logic        sel_s3_r;
    logic        strap_s1_r;
    logic        strap_s2_r;
    logic        miso_s1_r;
    logic        miso_s2_r;
    logic [1:0]  strap_wait_r;
    sbl_state_t  state_r;
    sbl_state_t  state_nxt;
    logic [7:0]  phase_r;
    logic [4:0]  mbits_r;
    logic [31:0] tx_r;
    logic [31:0] mrx_r;
    logic        sck_r;
    logic [8:0]  remain_r;
    logic [8:0]  mem_addr_r;
    logic [31:0] rxbuf_r;
    logic        break_r;
    logic [31:0] rdata_r;
    sbl_mem_wr_t mem_wr_r;
    logic        master_run;
    logic        sample_pt;
    logic        slave_word;
    logic        master_word;
    logic        word_in;
    logic [31:0] word_data;
    logic        dma_on;
    logic        last_word;
    logic [31:0] mrx_nxt;
    logic        sel_rise;
    logic        sel_fall;

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tog_s1_r   <= 1'b0;
            tog_s2_r   <= 1'b0;
            tog_s3_r   <= 1'b0;
            sel_s1_r   <= 1'b1;
            sel_s2_r   <= 1'b1;
            sel_s3_r   <= 1'b1;
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
            miso_s1_r  <= 1'b0;
            miso_s2_r  <= 1'b0;
        end else begin
            tog_s1_r   <= lnk_tog_r;
            tog_s2_r   <= tog_s1_r;
            tog_s3_r   <= tog_s2_r;
            sel_s1_r   <= DEVICE_SELECT_N_IN;
            sel_s2_r   <= sel_s1_r;
            sel_s3_r   <= sel_s2_r;
            strap_s1_r <= BOOT_MASTER_IN;
            strap_s2_r <= strap_s1_r;
            miso_s1_r  <= MASTER_DATA_IN;
            miso_s2_r  <= miso_s1_r;
        end
    end

    assign sel_rise    = sel_s2_r & ~sel_s3_r;
    assign sel_fall    = ~sel_s2_r & sel_s3_r;
    assign master_run  = (state_r == ST_CMD) || (state_r == ST_MDATA);
    assign sample_pt   = master_run && (phase_r == PERIOD_LAST);
    assign slave_word  = (state_r == ST_SDATA) && (tog_s2_r ^ tog_s3_r);
    assign mrx_nxt     = sbl_shift_in(mrx_r, miso_s2_r,
                                      ctrl_r.msb_first_bit);
    assign master_word = (state_r == ST_MDATA) && sample_pt &&
                         (mbits_r == 5'h1f);
    assign word_in     = slave_word | master_word;
    assign word_data   = slave_word ? lnk_word_r : mrx_nxt;
    assign dma_on      = ctrl_r.port_enable_bit &
                         ctrl_r.receive_dma_enable_bit;
    assign last_word   = word_in && dma_on && (remain_r == 9'h001);

    // Strap waits for the synchroniser before it is caught
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            strap_wait_r <= 2'h0;
        end else if (strap_wait_r != 2'h3) begin
            strap_wait_r <= strap_wait_r + 2'h1;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_STRAP: begin
                if (strap_wait_r == 2'h3) begin
                    state_nxt = strap_s2_r ? ST_CMD : ST_SARM;
                end
            end
            ST_SARM: begin
                // Words count only after a fresh high-to-low select edge
                if (sel_fall) begin
                    state_nxt = ST_SDATA;
                end
            end
            ST_SDATA: begin
                if (last_word) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_CMD: begin
                if (sample_pt && mbits_r == 5'h1f) begin
                    state_nxt = ST_MDATA;
                end
            end
            ST_MDATA: begin
                if (last_word) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                state_nxt = ST_DONE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= ST_STRAP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Control register: boot defaults, role from the strap
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_r <= CTRL_RESET;
        end else if (state_r == ST_STRAP && strap_wait_r == 2'h3) begin
            ctrl_r.master_select_bit <= strap_s2_r;
        end else if (REG_WR && REG_ADDR == REG_CTRL) begin
            ctrl_r                   <= sbl_ctrl_t'(REG_WDATA[9:0]);
            ctrl_r.word_length_field <= WL_32BIT;
        end
    end

    // Serial clock divider; clock idles high and stops outside the load
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            phase_r <= 8'h00;
            sck_r   <= 1'b1;
        end else if (master_run) begin
            phase_r <= (phase_r == PERIOD_LAST) ? 8'h00 : phase_r + 8'h01;
            sck_r   <= (phase_r >= HALF_CNT);
        end else begin
            phase_r <= 8'h00;
            sck_r   <= 1'b1;
        end
    end

    // Command word shifts out LSB first; reversed opcode reads 0x03 MSB
    // first at the memory
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_r <= {READ_ADDR, sbl_rev8(READ_OPCODE)};
        end else if (sample_pt) begin
            tx_r <= {1'b0, tx_r[31:1]};
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            mbits_r <= 5'h00;
        end else if (sample_pt) begin
            mbits_r <= mbits_r + 5'h01;
        end
    end

    // Receive shifter only runs after the command word, so the bits that
    // arrive with the command never reach mrx_r or the memory
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            mrx_r <= 32'h00000000;
        end else if (sample_pt && state_r == ST_MDATA) begin
            mrx_r <= mrx_nxt;
        end
    end

    // Receive DMA into kernel memory
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            remain_r   <= DMA_WORDS;
            mem_addr_r <= 9'h000;
            mem_wr_r   <= '0;
            rxbuf_r    <= 32'h00000000;
        end else begin
            mem_wr_r.we <= 1'b0;
            if (word_in && dma_on) begin
                mem_wr_r.we   <= 1'b1;
                mem_wr_r.addr <= mem_addr_r;
                mem_wr_r.data <= word_data;
                rxbuf_r       <= word_data;
                mem_addr_r    <= mem_addr_r + 9'h001;
                remain_r      <= remain_r - 9'h001;
            end
        end
    end

    // Select lifted mid-load; set wins over a write-one clear
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            break_r <= 1'b0;
        end else if (state_r == ST_SDATA && sel_rise) begin
            break_r <= 1'b1;
        end else if (REG_WR && REG_ADDR == REG_STATUS &&
                     REG_WDATA[STAT_BREAK]) begin
            break_r <= 1'b0;
        end
    end

    // Register reads answer one cycle after the strobe
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_r <= 32'h00000000;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                REG_CTRL:   rdata_r <= {22'h000000, ctrl_r};
                REG_STATUS: rdata_r <= {25'h0000000, 3'(state_r), break_r,
                                        sel_s2_r,
                                        ctrl_r.master_select_bit,
                                        state_r == ST_DONE};
                REG_RXBUF:  rdata_r <= rxbuf_r;
                REG_COUNT:  rdata_r <= {23'h000000, remain_r};
                default:    rdata_r <= 32'h00000000;
            endcase
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    assign REG_RDATA         = rdata_r;
    assign MEM_WR            = mem_wr_r;
    assign KERNEL_DONE       = (state_r == ST_DONE);
    assign SCK_OUT           = sck_r;
    assign SCK_OE            = master_run;
    assign SER_OUT           = tx_r[0];
    assign SER_OUT_OE        = master_run;
    assign FLAG_SELECT_N_OUT = ~master_run;

endmodule : sbl_port

// ===== testbench/sbl_host_model.sv
// Behavioural serial host and serial flash facing the boot port
`timescale 1ns/10ps
module sbl_host_model (
    // Master boot side, driven by the port
    input  wire logic sck_in,
    input  wire logic flag_n_in,
    input  wire logic ser_in,
    // Link pins toward the port
    output logic      link_sck,
    output logic      sel_n,
    output logic      sdata,
    output logic      mdata
);
    logic [31:0] mem [4];
    logic [31:0] cmd_r;
    int          falls;
    int          rises;

    initial begin
        link_sck = 1'b1;
        sel_n    = 1'b1;
        sdata    = 1'b0;
        mdata    = 1'b0;
        cmd_r    = 32'h00000000;
        falls    = 0;
        rises    = 0;
    end

    // Clock idles high and falls at the start of each bit; calls run
    // back to back so the stream has no gaps
    task automatic send_bits(input logic [31:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            link_sck = 1'b0;
            sdata    = w[i];
            #7.5;
            link_sck = 1'b1;
            #7.5;
        end
    endtask : send_bits

    // Flash answers junk under the command, then the stored words
    always @(negedge sck_in) begin
        if (!flag_n_in) begin
            if (falls < 32) begin
                mdata <= ~falls[0];
            end else if (falls < 160) begin
                mdata <= mem[(falls - 32) / 32][(falls - 32) % 32];
            end else begin
                mdata <= ~mdata;
            end
            falls <= falls + 1;
        end
    end

    always @(posedge sck_in) begin
        if (!flag_n_in && rises < 32) begin
            cmd_r[rises] <= ser_in;
            rises        <= rises + 1;
        end
    end

    // Deselected: the line no longer holds its last value
    always @(posedge flag_n_in) begin
        falls <= 0;
        rises <= 0;
        mdata <= ~mdata;
    end
endmodule : sbl_host_model

// ===== testbench/sbl_port_asserts.sv
// Concurrent checks on the pins of the SPI boot loader port
`timescale 1ns/10ps
module sbl_port_asserts
    import sbl_pkg::*;
#(
    parameter logic [8:0] DMA_WORDS = sbl_pkg::KERNEL_WORDS
) (
    // Clock and reset
    input wire logic                 SYS_CLK,
    input wire logic                 RSTN,
    // Register port
    input wire logic [3:0]           REG_ADDR,
    input wire logic                 REG_RD,
    input wire logic [31:0]          REG_RDATA,
    // Master link and memory side
    input wire logic                 SCK_OUT,
    input wire logic                 SCK_OE,
    input wire logic                 SER_OUT,
    input wire logic                 SER_OUT_OE,
    input wire logic                 FLAG_SELECT_N_OUT,
    input wire sbl_pkg::sbl_mem_wr_t MEM_WR,
    input wire logic                 KERNEL_DONE
);
    logic [15:0] falls_r;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    // Master clock periods seen since the select went low
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            falls_r <= 16'h0000;
        end else if (FLAG_SELECT_N_OUT) begin
            falls_r <= 16'h0000;
        end else if ($fell(SCK_OUT)) begin
            falls_r <= falls_r + 16'h0001;
        end
    end

    wl_fixed_a: assert property (
        $past(REG_RD) && $past(REG_ADDR) == REG_CTRL |->
        REG_RDATA[4:3] == WL_32BIT) else $error("word length not fixed");
    one_word_a: assert property (
        MEM_WR.we |=> !MEM_WR.we) else $error("store pulse too long");
    word_addr_a: assert property (
        MEM_WR.we |-> MEM_WR.addr < DMA_WORDS) else $error("store past count");
    done_hold_a: assert property (
        KERNEL_DONE |=> KERNEL_DONE) else $error("done dropped");
    done_release_a: assert property (
        KERNEL_DONE |-> FLAG_SELECT_N_OUT && !SCK_OE && SCK_OUT)
        else $error("link not released at done");
    clk_select_a: assert property (
        $changed(SCK_OUT) |-> SCK_OE && !FLAG_SELECT_N_OUT)
        else $error("clock moved without select");
    ser_first_a: assert property (
        $fell(FLAG_SELECT_N_OUT) |-> SER_OUT_OE && !SER_OUT)
        else $error("first command bit not zero");
    clk_start_a: assert property (
        $fell(FLAG_SELECT_N_OUT) |-> SCK_OE ##[0:3] !SCK_OUT)
        else $error("clock did not start");
    cmd_drive_a: assert property (
        !FLAG_SELECT_N_OUT |-> SER_OUT_OE) else $error("command not driven");
    cmd_dropped_a: assert property (
        MEM_WR.we && !FLAG_SELECT_N_OUT |-> falls_r >= 16'h0040)
        else $error("word stored from command time");
endmodule : sbl_port_asserts

bind sbl_port sbl_port_asserts #(.DMA_WORDS(DMA_WORDS)) chk_u (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE),
    .SER_OUT(SER_OUT),
    .SER_OUT_OE(SER_OUT_OE), .FLAG_SELECT_N_OUT(FLAG_SELECT_N_OUT),
    .MEM_WR(MEM_WR), .KERNEL_DONE(KERNEL_DONE));

// ===== testbench/test_spi_boot_loader_port.sv
// Self-checking bench for slave and master boot of the boot port
`timescale 1ns/10ps
module test_spi_boot_loader_port;
    import sbl_pkg::*;
    localparam logic [8:0] NW = 9'h004;
    logic        sys_clk, rstn, boot_m, reg_wr, reg_rd;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd, lfsr_r;
    logic        link_sck, sel_n, sdata, mdata;
    logic        sck_out, sck_oe, ser_out, ser_oe, flag_n, kdone;
    sbl_mem_wr_t mem_wr;
    logic [31:0] exp_w [4];
    logic [40:0] got_q [$];
    int          miscompares;
    int          num_checks;

    always #2 sys_clk = ~sys_clk;

    sbl_port #(.DMA_WORDS(NW)) dut_u (
        .SYS_CLK(sys_clk), .RSTN(rstn), .BOOT_MASTER_IN(boot_m),
        .LINK_SCK(link_sck), .DEVICE_SELECT_N_IN(sel_n),
        .SLAVE_DATA_IN(sdata), .MASTER_DATA_IN(mdata), .SCK_OUT(sck_out),
        .SCK_OE(sck_oe), .SER_OUT(ser_out), .SER_OUT_OE(ser_oe),
        .FLAG_SELECT_N_OUT(flag_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .MEM_WR(mem_wr), .KERNEL_DONE(kdone));

    sbl_host_model host_u (
        .sck_in(sck_out), .flag_n_in(flag_n), .ser_in(ser_out),
        .link_sck(link_sck), .sel_n(sel_n), .sdata(sdata), .mdata(mdata));

    always @(posedge sys_clk) begin
        if (mem_wr.we === 1'b1) begin
            got_q.push_back({mem_wr.addr, mem_wr.data});
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // First bit on the wire lands in bit 0 of the captured word
    function automatic logic [31:0] cmd_word();
        logic [31:0] w;
        w = {READ_ADDR, 8'h00};
        for (int i = 0; i < 8; i++) begin
            w[i] = READ_OPCODE[7-i];
        end
        return w;
    endfunction : cmd_word

    // Word as assembled when the first bit on the wire is the top bit
    function automatic logic [31:0] rev32(input logic [31:0] v);
        logic [31:0] r;
        for (int i = 0; i < 32; i++) begin
            r[i] = v[31-i];
        end
        return r;
    endfunction : rev32

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("TB: checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // Strap is held through reset; fresh random kernel each boot
    task automatic boot(input logic m);
        @(posedge sys_clk);
        rstn   <= 1'b0;
        boot_m <= m;
        got_q.delete();
        for (int i = 0; i < 4; i++) begin
            lfsr_r          = lfsr_next(lfsr_r);
            exp_w[i]        = lfsr_r;
            host_u.mem[i]   = lfsr_r;
        end
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
    endtask : boot

    task automatic finish_load(input logic msb);
        logic [31:0] e;
        for (int i = 0; i < 4000 && kdone !== 1'b1; i++) begin
            @(posedge sys_clk);
        end
        // Let the store seen at this edge reach the queue first
        @(posedge sys_clk);
        check(kdone, 1'b1);
        check(64'(got_q.size()), 64'(NW));
        for (int i = 0; i < 4; i++) begin
            e = msb ? rev32(exp_w[i]) : exp_w[i];
            check(got_q[i], {i[8:0], e});
        end
    endtask : finish_load

    initial begin
        sys_clk = 1'b0; rstn = 1'b0; boot_m = 1'b0;
        reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
        reg_wdata = 32'h00000000; lfsr_r = 32'h3694033e;
        miscompares = 0; num_checks = 0;
        boot(1'b0);
        reg_read(REG_CTRL, rd);
        check(rd, 32'h000003b1);
        reg_read(4'h2, rd);
        check(rd, 32'h00000000);
        repeat (10) @(posedge sys_clk);
        #1.3 host_u.sel_n = 1'b0;
        host_u.send_bits(exp_w[3], 5);
        host_u.sel_n = 1'b1;
        #200 host_u.sel_n = 1'b0;
        #30;
        for (int i = 0; i < 4; i++) begin
            host_u.send_bits(exp_w[i], 32);
        end
        host_u.sdata = ~host_u.sdata;
        finish_load(1'b0);
        host_u.sel_n = 1'b1;
        reg_read(REG_STATUS, rd);
        check(rd & 32'h9, 32'h9);
        reg_read(REG_RXBUF, rd);
        check(rd, exp_w[3]);
        reg_write(REG_STATUS, 32'h00000008);
        reg_read(REG_STATUS, rd);
        check(rd & 32'h9, 32'h1);
        reg_write(REG_CTRL, 32'hffffffff);
        reg_read(REG_CTRL, rd);
        check(rd, 32'h000003f7);
        $display("TB: slave boot test done");
        boot(1'b1);
        reg_write(REG_CTRL, 32'h000003b7);
        reg_read(REG_CTRL, rd);
        check(rd, 32'h000003b7);
        finish_load(1'b1);
        check(host_u.cmd_r, cmd_word());
        check({flag_n, sck_oe, sck_out}, 3'b101);
        $display("TB: master boot test done");
        tally_and_finish();
    end

    // Both boots need well under a tenth of this span
    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
endmodule : test_spi_boot_loader_port
